// ---- hw/kmrc_menu_ctrl.sv ----
// Functional notes
// - home key always returns to run menu
// - next and previous keys step the list
// - step changes digit, pick selects digit
// - access key unlocks and opens submenu below
// - committed settings written to both memories
// - key press lights display, off after 10min
// - fault shows flashing triangles in fault field
// - config entered after 2s home hold
// - config has view and change modes
// - change mode needs passcode, factory 1000
// - power-up starts in run menu flow page
// - main menu has six entries, next steps
// - submenus exit only to run, by home or config idle
// - converter setup holds three submenus
// - compact unit: one assignable relay
// - rack: relay1 any, relay2 direction/sound
// - relay energized on normal, reverse, out-of-range
// - config idle 10min returns to run menu; timer runs from config entry, key presses do not restart it
// - home held through self-test restores 1000
// - service forces cancelled on leaving service
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
module kmrc_menu_ctrl #(
  parameter bit          RACK_UNIT       = 1'b1,
  parameter int unsigned MS_CYCLES       = kmrc_pkg::MS_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = kmrc_pkg::DEBOUNCE_CYCLES,
  parameter int unsigned HOME_HOLD_MS    = kmrc_pkg::HOME_HOLD_MS,
  parameter int unsigned BACKLIGHT_MS    = kmrc_pkg::BACKLIGHT_MS,
  parameter int unsigned CFG_IDLE_MS     = kmrc_pkg::CFG_IDLE_MS,
  parameter int unsigned FAULT_BLINK_MS  = kmrc_pkg::FAULT_BLINK_MS,
  parameter int unsigned RUN_PAGES       = kmrc_pkg::RUN_PAGES
) (
  // clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  // front panel and process pins
  input  wire logic [5:0]              key_raw,
  input  wire logic                    fault_raw,
  input  wire logic                    reverse_raw,
  input  wire logic                    sound_out_raw,
  input  wire logic                    selftest_done_raw,
  // register port
  input  wire logic [7:0]              reg_addr,
  input  wire logic [31:0]             reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [31:0]             reg_rdata,
  // display
  output kmrc_pkg::kmrc_disp_type      disp,
  output logic                         backlight_on,
  output logic                         fault_flash,
  // relays and nonvolatile store
  output logic                         relay1_on,
  output logic                         relay2_on,
  output kmrc_pkg::kmrc_nv_type        nv
);

  localparam int unsigned MS_W  = $clog2(MS_CYCLES + 1);
  localparam int unsigned HLD_W = $clog2(HOME_HOLD_MS + 1);
  localparam int unsigned BL_W  = $clog2(BACKLIGHT_MS + 1);
  localparam int unsigned CI_W  = $clog2(CFG_IDLE_MS + 1);
  localparam int unsigned BK_W  = $clog2(FAULT_BLINK_MS + 1);

  function automatic logic [15:0] bcd_step(input logic [15:0] v, input logic [1:0] d);
    logic [3:0]  nib;
    logic [15:0] r;
    nib = v[{d, 2'b00} +: 4];
    r   = v;
    r[{d, 2'b00} +: 4] = (nib >= 4'h9) ? 4'h0 : nib + 4'h1;
    return r;
  endfunction

  // error: normal energizes; direction: reverse; sound: out of range
  function automatic logic relay_drive(input logic [1:0] fn, input kmrc_pkg::kmrc_sense_type s);
    case (fn)
      kmrc_pkg::RFN_DIRECTION: relay_drive = s.reverse;
      kmrc_pkg::RFN_SOUND:     relay_drive = s.sound_out;
      default:                 relay_drive = ~s.fault;
    endcase
  endfunction

  kmrc_pkg::kmrc_sense_type sense_meta_q, sense_q;
  logic [5:0] key_lvl, key_press;

  always_ff @(posedge sys_clk) begin
    sense_meta_q <= {fault_raw, reverse_raw, sound_out_raw, selftest_done_raw};
    sense_q      <= sense_meta_q;
  end

  kmrc_key_filter #(
    .N             (kmrc_pkg::NUM_KEYS),
    .SAMPLE_CYCLES (DEBOUNCE_CYCLES)
  ) u_keys (
    .sys_clk (sys_clk),
    .srst    (srst),
    .raw     (key_raw),
    .level   (key_lvl),
    .press   (key_press)
  );

  logic [MS_W-1:0] ms_q;
  logic            ms_tick;
  assign ms_tick = (ms_q == MS_W'(MS_CYCLES - 1));
  always_ff @(posedge sys_clk) begin
    if (srst || ms_tick) begin
      ms_q <= '0;
    end else begin
      ms_q <= ms_q + MS_W'(1);
    end
  end

  // menu and edit state
  kmrc_pkg::kmrc_menu_type menu_q, menu_d;
  logic              chg_q, chg_d, permit_q, permit_d, boot_q, boot_d;
  logic [2:0]        page_q, page_d, entry_q, entry_d;
  logic [1:0]        item_q, item_d, dig_q, dig_d;
  logic [15:0]       val_q, val_d, code_q, code_d;
  logic [HLD_W-1:0]  hold_q, hold_d;
  logic [CI_W-1:0]   idle_q, idle_d;
  kmrc_pkg::kmrc_nv_type nv_q, nv_d;
  logic              set_we;
  logic [15:0]       settings [32];
  logic [4:0]        cur_idx, set_idx_q;
  logic [15:0]       cur_val;
  logic              in_service;

  assign cur_idx    = {entry_q, item_q};
  assign cur_val    = (entry_q == kmrc_pkg::ENTRY_PASSCODE) ? code_q : settings[cur_idx];
  assign in_service = (menu_q == kmrc_pkg::M_SUB || menu_q == kmrc_pkg::M_EDIT)
                      && entry_q == kmrc_pkg::ENTRY_SERVICE;

  always_comb begin
    logic commit;
    commit   = 1'b0;
    menu_d   = menu_q;
    chg_d    = chg_q;
    permit_d = permit_q;
    boot_d   = boot_q;
    page_d   = page_q;
    entry_d  = entry_q;
    item_d   = item_q;
    dig_d    = dig_q;
    val_d    = val_q;
    code_d   = code_q;
    set_we   = 1'b0;
    nv_d     = '0;
    hold_d   = key_lvl[kmrc_pkg::KEY_HOME] ? hold_q : '0;
    if (key_lvl[kmrc_pkg::KEY_HOME] && ms_tick && hold_q != HLD_W'(HOME_HOLD_MS)) begin
      hold_d = hold_q + HLD_W'(1);
    end
    idle_d = '0;
    if (menu_q != kmrc_pkg::M_RUN) begin
      idle_d = idle_q + ((ms_tick && idle_q != CI_W'(CFG_IDLE_MS)) ? CI_W'(1) : CI_W'(0));
    end
    if (reg_wr && reg_addr == kmrc_pkg::REG_PASSCODE) begin
      code_d = reg_wdata[15:0];
    end

    if (idle_q == CI_W'(CFG_IDLE_MS)) begin
      menu_d = kmrc_pkg::M_RUN;
      page_d = '0;
    end else if (key_press[kmrc_pkg::KEY_HOME]) begin
      menu_d   = kmrc_pkg::M_RUN;
      page_d   = '0;
      permit_d = 1'b0;
    end else if (key_lvl[kmrc_pkg::KEY_HOME] && ms_tick
                 && hold_q == HLD_W'(HOME_HOLD_MS - 1)) begin
      menu_d   = kmrc_pkg::M_MODE;
      chg_d    = 1'b0;
      permit_d = 1'b0;
    end else begin
      unique case (menu_q)
        kmrc_pkg::M_RUN: begin
          if (key_press[kmrc_pkg::KEY_NEXT]) begin
            page_d = (page_q == 3'(RUN_PAGES - 1)) ? 3'h0 : page_q + 3'h1;
          end else if (key_press[kmrc_pkg::KEY_PREV]) begin
            page_d = (page_q == 3'h0) ? 3'(RUN_PAGES - 1) : page_q - 3'h1;
          end
        end
        kmrc_pkg::M_MODE: begin
          if (key_press[kmrc_pkg::KEY_NEXT] || key_press[kmrc_pkg::KEY_PREV]) begin
            chg_d = ~chg_q;
          end else if (key_press[kmrc_pkg::KEY_ACCESS]) begin
            val_d = '0;
            dig_d = '0;
            if (chg_q) begin
              menu_d = kmrc_pkg::M_CODE;
            end else begin
              menu_d  = kmrc_pkg::M_MAIN;
              entry_d = '0;
            end
          end
        end
        kmrc_pkg::M_CODE: begin
          if (key_press[kmrc_pkg::KEY_STEP]) begin
            val_d = bcd_step(val_q, dig_q);
          end else if (key_press[kmrc_pkg::KEY_PICK]) begin
            dig_d = dig_q + 2'h1;
          end else if (key_press[kmrc_pkg::KEY_ACCESS]) begin
            permit_d = (val_q == code_q);
            menu_d   = kmrc_pkg::M_MAIN;
            entry_d  = '0;
          end
        end
        kmrc_pkg::M_MAIN: begin
          if (key_press[kmrc_pkg::KEY_NEXT]) begin
            entry_d = (entry_q == kmrc_pkg::ENTRY_LAST) ? 3'h0 : entry_q + 3'h1;
          end else if (key_press[kmrc_pkg::KEY_PREV]) begin
            entry_d = (entry_q == 3'h0) ? kmrc_pkg::ENTRY_LAST : entry_q - 3'h1;
          end else if (key_press[kmrc_pkg::KEY_ACCESS]) begin
            menu_d = kmrc_pkg::M_SUB;
            item_d = '0;
          end
        end
        kmrc_pkg::M_SUB: begin
          // no key leads back to the main menu from here
          if (key_press[kmrc_pkg::KEY_NEXT]) begin
            item_d = (item_q == kmrc_pkg::items_last(entry_q)) ? 2'h0 : item_q + 2'h1;
          end else if (key_press[kmrc_pkg::KEY_PREV]) begin
            item_d = (item_q == 2'h0) ? kmrc_pkg::items_last(entry_q) : item_q - 2'h1;
          end else if (key_press[kmrc_pkg::KEY_ACCESS] && permit_q) begin
            menu_d = kmrc_pkg::M_EDIT;
            val_d  = cur_val;
            dig_d  = '0;
          end
        end
        kmrc_pkg::M_EDIT: begin
          if (key_press[kmrc_pkg::KEY_STEP]) begin
            val_d = bcd_step(val_q, dig_q);
          end else if (key_press[kmrc_pkg::KEY_PICK]) begin
            dig_d = dig_q + 2'h1;
          end else if (key_press[kmrc_pkg::KEY_ACCESS]) begin
            menu_d = kmrc_pkg::M_SUB;
            commit = 1'b1;
          end
        end
      endcase
    end

    if (commit) begin
      nv_d = '{conv_we: 1'b1, sensor_we: 1'b1, addr: cur_idx, data: val_q};
      if (entry_q == kmrc_pkg::ENTRY_PASSCODE) begin
        code_d = val_q;
      end else begin
        set_we = 1'b1;
      end
    end

    // home held until self-tests finish restores the factory passcode
    if (boot_q && sense_q.selftest_done) begin
      boot_d = 1'b0;
      if (key_lvl[kmrc_pkg::KEY_HOME]) begin
        code_d = kmrc_pkg::FACTORY_PASSCODE;
        nv_d   = '{conv_we: 1'b1, sensor_we: 1'b1, addr: kmrc_pkg::PASSCODE_NV_ADDR,
                   data: kmrc_pkg::FACTORY_PASSCODE};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      menu_q   <= kmrc_pkg::M_RUN;
      chg_q    <= 1'b0;
      permit_q <= 1'b0;
      boot_q   <= 1'b1;
      page_q   <= '0;
      entry_q  <= '0;
      item_q   <= '0;
      dig_q    <= '0;
      val_q    <= '0;
      code_q   <= kmrc_pkg::FACTORY_PASSCODE;
      hold_q   <= '0;
      idle_q   <= '0;
      nv_q     <= '0;
    end else begin
      menu_q   <= menu_d;
      chg_q    <= chg_d;
      permit_q <= permit_d;
      boot_q   <= boot_d;
      page_q   <= page_d;
      entry_q  <= entry_d;
      item_q   <= item_d;
      dig_q    <= dig_d;
      val_q    <= val_d;
      code_q   <= code_d;
      hold_q   <= hold_d;
      idle_q   <= idle_d;
      nv_q     <= nv_d;
    end
  end

  // settings copy held locally, not reset: loaded only by edit commits, read back through REG_SET_DATA
  always_ff @(posedge sys_clk) begin
    if (set_we) begin
      settings[cur_idx] <= val_q;
    end
  end

  // backlight, fault blink, relays, registers
  logic [BL_W-1:0] bl_q, bl_d;
  logic            bl_on_q, bl_on_d;
  logic [BK_W-1:0] bk_q, bk_d;
  logic            blink_q, blink_d, flash_q, flash_d;
  logic [3:0]      ctrl_q, ctrl_d, force_q, force_d;
  logic            r1_q, r1_d, r2_q, r2_d;
  logic [31:0]     rdata_q, rdata_d;
  logic [4:0]      set_idx_d;
  kmrc_pkg::kmrc_status_type st;

  assign st = '{item: item_q, entry: entry_q, relay2: r2_q, relay1: r1_q,
                fault: sense_q.fault, backlight: bl_on_q, write_ok: permit_q, menu: menu_q};

  always_comb begin
    logic [1:0] r2_fn;
    r2_fn   = ctrl_q[kmrc_pkg::CTRL_R2_FN_LSB +: 2];
    bl_d    = (bl_q != BL_W'(BACKLIGHT_MS) && ms_tick) ? bl_q + BL_W'(1) : bl_q;
    bl_on_d = bl_on_q && (bl_q != BL_W'(BACKLIGHT_MS));
    if (|key_press) begin
      bl_d    = '0;
      bl_on_d = 1'b1;
    end
    bk_d    = bk_q;
    blink_d = blink_q;
    if (ms_tick) begin
      bk_d = bk_q + BK_W'(1);
      if (bk_q == BK_W'(FAULT_BLINK_MS - 1)) begin
        bk_d    = '0;
        blink_d = ~blink_q;
      end
    end
    flash_d = sense_q.fault & blink_q;
    ctrl_d  = (reg_wr && reg_addr == kmrc_pkg::REG_CTRL) ? reg_wdata[3:0] : ctrl_q;
    force_d = force_q;
    if (!in_service) begin
      force_d = kmrc_pkg::FORCE_RESET;
    end else if (reg_wr && reg_addr == kmrc_pkg::REG_FORCE) begin
      force_d = reg_wdata[3:0];
    end
    set_idx_d = (reg_wr && reg_addr == kmrc_pkg::REG_SET_IDX) ? reg_wdata[4:0] : set_idx_q;
    r1_d = relay_drive(ctrl_q[kmrc_pkg::CTRL_R1_FN_LSB +: 2], sense_q);
    if (force_q[kmrc_pkg::FORCE_R1_EN]) begin
      r1_d = force_q[kmrc_pkg::FORCE_R1_VAL];
    end
    // relay 2 has no error function; that code falls back to direction
    r2_d = relay_drive((r2_fn == kmrc_pkg::RFN_SOUND) ? kmrc_pkg::RFN_SOUND
                       : kmrc_pkg::RFN_DIRECTION, sense_q);
    if (force_q[kmrc_pkg::FORCE_R2_EN]) begin
      r2_d = force_q[kmrc_pkg::FORCE_R2_VAL];
    end
    r2_d    = r2_d & RACK_UNIT;
    rdata_d = '0;
    if (reg_rd) begin
      case (reg_addr)
        kmrc_pkg::REG_CTRL:     rdata_d = {28'h0, ctrl_q};
        kmrc_pkg::REG_FORCE:    rdata_d = {28'h0, force_q};
        kmrc_pkg::REG_PASSCODE: rdata_d = {16'h0, code_q};
        kmrc_pkg::REG_STATUS:   rdata_d = {19'h0, st};
        kmrc_pkg::REG_SET_IDX:  rdata_d = {27'h0, set_idx_q};
        kmrc_pkg::REG_SET_DATA: rdata_d = {16'h0, settings[set_idx_q]};
        default:                rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      bl_q      <= '0;
      bl_on_q   <= 1'b1;
      bk_q      <= '0;
      blink_q   <= 1'b0;
      flash_q   <= 1'b0;
      ctrl_q    <= kmrc_pkg::CTRL_RESET;
      force_q   <= kmrc_pkg::FORCE_RESET;
      set_idx_q <= '0;
      r1_q      <= 1'b0;
      r2_q      <= 1'b0;
      rdata_q   <= '0;
    end else begin
      bl_q      <= bl_d;
      bl_on_q   <= bl_on_d;
      bk_q      <= bk_d;
      blink_q   <= blink_d;
      flash_q   <= flash_d;
      ctrl_q    <= ctrl_d;
      force_q   <= force_d;
      set_idx_q <= set_idx_d;
      r1_q      <= r1_d;
      r2_q      <= r2_d;
      rdata_q   <= rdata_d;
    end
  end

  assign disp = '{menu: menu_q, write_ok: permit_q, change_sel: chg_q, run_page: page_q,
                  entry: entry_q, item: item_q, digit: dig_q,
                  value: (menu_q == kmrc_pkg::M_CODE || menu_q == kmrc_pkg::M_EDIT)
                         ? val_q : 16'h0000};
  assign backlight_on = bl_on_q;
  assign fault_flash  = flash_q;
  assign relay1_on    = r1_q;
  assign relay2_on    = r2_q;
  assign nv           = nv_q;
  assign reg_rdata    = rdata_q;

endmodule

// ---- hw/kmrc_pkg.sv ----
package kmrc_pkg;

  // clock and timing, each time in its own unit
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned KEY_DEBOUNCE_MS = 10;
  localparam int unsigned HOME_HOLD_S     = 2;
  localparam int unsigned BACKLIGHT_MIN   = 10;
  localparam int unsigned CFG_IDLE_MIN    = 10;
  localparam int unsigned FAULT_BLINK_MS  = 250;
  localparam int unsigned MS_CYCLES       = CLK_HZ / 1000;
  localparam int unsigned DEBOUNCE_CYCLES = KEY_DEBOUNCE_MS * MS_CYCLES;
  localparam int unsigned HOME_HOLD_MS    = HOME_HOLD_S * 1000;
  localparam int unsigned BACKLIGHT_MS    = BACKLIGHT_MIN * 60_000;
  localparam int unsigned CFG_IDLE_MS     = CFG_IDLE_MIN * 60_000;

  // key positions in the key vector
  localparam int unsigned NUM_KEYS   = 6;
  localparam int unsigned KEY_HOME   = 0;
  localparam int unsigned KEY_NEXT   = 1;
  localparam int unsigned KEY_PREV   = 2;
  localparam int unsigned KEY_STEP   = 3;
  localparam int unsigned KEY_PICK   = 4;
  localparam int unsigned KEY_ACCESS = 5;

  // configuration main menu entries
  localparam logic [2:0] ENTRY_CONVERTER = 3'h0;
  localparam logic [2:0] ENTRY_RESET     = 3'h1;
  localparam logic [2:0] ENTRY_SERVICE   = 3'h2;
  localparam logic [2:0] ENTRY_LANGUAGE  = 3'h3;
  localparam logic [2:0] ENTRY_RUN_SETUP = 3'h4;
  localparam logic [2:0] ENTRY_PASSCODE  = 3'h5;
  localparam logic [2:0] ENTRY_LAST      = 3'h5;
  localparam int unsigned RUN_PAGES      = 4;

  // passcode, four bcd digits
  localparam logic [15:0] FACTORY_PASSCODE = 16'h1000;
  localparam logic [4:0]  PASSCODE_NV_ADDR = 5'h14;

  // register offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_FORCE    = 8'h04;
  localparam logic [7:0] REG_PASSCODE = 8'h08;
  localparam logic [7:0] REG_STATUS   = 8'h0c;
  localparam logic [7:0] REG_SET_IDX  = 8'h10;
  localparam logic [7:0] REG_SET_DATA = 8'h14;

  // field positions and reset values
  localparam int unsigned CTRL_R1_FN_LSB  = 0;
  localparam int unsigned CTRL_R2_FN_LSB  = 2;
  localparam int unsigned FORCE_R1_EN     = 0;
  localparam int unsigned FORCE_R1_VAL    = 1;
  localparam int unsigned FORCE_R2_EN     = 2;
  localparam int unsigned FORCE_R2_VAL    = 3;
  localparam logic [3:0]  CTRL_RESET      = 4'h4;
  localparam logic [3:0]  FORCE_RESET     = 4'h0;

  // relay functions
  localparam logic [1:0] RFN_ERROR     = 2'h0;
  localparam logic [1:0] RFN_DIRECTION = 2'h1;
  localparam logic [1:0] RFN_SOUND     = 2'h2;

  typedef enum logic [2:0] {
    M_RUN, M_MODE, M_CODE, M_MAIN, M_SUB, M_EDIT
  } kmrc_menu_type;

  typedef struct packed {
    kmrc_menu_type menu;
    logic          write_ok;
    logic          change_sel;
    logic [2:0]    run_page;
    logic [2:0]    entry;
    logic [1:0]    item;
    logic [1:0]    digit;
    logic [15:0]   value;
  } kmrc_disp_type;

  typedef struct packed {
    logic        conv_we;
    logic        sensor_we;
    logic [4:0]  addr;
    logic [15:0] data;
  } kmrc_nv_type;

  typedef struct packed {
    logic fault;
    logic reverse;
    logic sound_out;
    logic selftest_done;
  } kmrc_sense_type;

  typedef struct packed {
    logic [1:0]    item;
    logic [2:0]    entry;
    logic          relay2;
    logic          relay1;
    logic          fault;
    logic          backlight;
    logic          write_ok;
    kmrc_menu_type menu;
  } kmrc_status_type;

  // last item index of each entry's submenu
  function automatic logic [1:0] items_last(input logic [2:0] entry);
    case (entry)
      ENTRY_CONVERTER: items_last = 2'h2;
      ENTRY_RESET:     items_last = 2'h1;
      ENTRY_SERVICE:   items_last = 2'h1;
      ENTRY_RUN_SETUP: items_last = 2'h3;
      default:         items_last = 2'h0;
    endcase
  endfunction

endpackage

// ---- hw/kmrc_key_filter.sv ----
module kmrc_key_filter #(
  parameter int unsigned N             = 6,
  parameter int unsigned SAMPLE_CYCLES = 400_000
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         srst,
  // raw pins and filtered result
  input  wire logic [N-1:0] raw,
  output logic      [N-1:0] level,
  output logic      [N-1:0] press
);

  localparam int unsigned CW = $clog2(SAMPLE_CYCLES + 1);

  logic [N-1:0]  meta_q;
  logic [N-1:0]  sync_q;
  logic [N-1:0]  samp_q, samp_d;
  logic [N-1:0]  stab_q, stab_d;
  logic [N-1:0]  press_q, press_d;
  logic [CW-1:0] cnt_q, cnt_d;

  always_ff @(posedge sys_clk) begin
    meta_q <= raw;
    sync_q <= meta_q;
  end

  // accept a level only when two samples a debounce period apart agree
  always_comb begin
    cnt_d   = cnt_q + CW'(1);
    samp_d  = samp_q;
    stab_d  = stab_q;
    press_d = '0;
    if (cnt_q == CW'(SAMPLE_CYCLES - 1)) begin
      cnt_d  = '0;
      samp_d = sync_q;
      for (int i = 0; i < N; i++) begin
        if (sync_q[i] == samp_q[i]) begin
          stab_d[i]  = sync_q[i];
          press_d[i] = sync_q[i] & ~stab_q[i];
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_q   <= '0;
      samp_q  <= '0;
      stab_q  <= '0;
      press_q <= '0;
    end else begin
      cnt_q   <= cnt_d;
      samp_q  <= samp_d;
      stab_q  <= stab_d;
      press_q <= press_d;
    end
  end

  assign level = stab_q;
  assign press = press_q;

endmodule

// ---- tb/kmrc_menu_ctrl_checker.sv ----
module kmrc_menu_ctrl_checker #(
  parameter int unsigned MS_CYCLES   = 4,
  parameter int unsigned CFG_IDLE_MS = 30
) (
  // clock and reset
  input wire logic                    sys_clk,
  input wire logic                    srst,
  // watched ports
  input wire logic [5:0]              key_raw,
  input wire kmrc_pkg::kmrc_disp_type disp,
  input wire logic                    backlight_on,
  input wire kmrc_pkg::kmrc_nv_type   nv
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic [3:0]  idle_q;
  logic [31:0] cfg_q;
  // key idle age saturates; config age in cycles
  always_ff @(posedge sys_clk) begin
    idle_q <= (!srst && key_raw == 6'h0) ? idle_q + {3'h0, idle_q != 4'hf} : 4'h0;
    cfg_q  <= (srst || disp.menu == kmrc_pkg::M_RUN) ? 32'h0 : cfg_q + 32'h1;
  end
  property p_nv;
    nv.conv_we || nv.sensor_we |-> nv.conv_we && nv.sensor_we && disp.write_ok;
  endproperty
  a_nv: assert property (p_nv) else $error("store pulse unpaired or locked");
  property p_wok;
    $rose(disp.write_ok) |-> disp.menu == kmrc_pkg::M_MAIN && $past(disp.menu) == kmrc_pkg::M_CODE;
  endproperty
  a_wok: assert property (p_wok) else $error("write access without code");
  property p_edit;
    disp.menu == kmrc_pkg::M_EDIT && $past(disp.menu) != kmrc_pkg::M_EDIT
      |-> $past(disp.menu) == kmrc_pkg::M_SUB && $past(disp.write_ok);
  endproperty
  a_edit: assert property (p_edit) else $error("edit opened while locked");
  property p_sub;
    disp.menu == kmrc_pkg::M_SUB && $past(disp.menu) != kmrc_pkg::M_SUB
      |-> $past(disp.menu) inside {kmrc_pkg::M_MAIN, kmrc_pkg::M_EDIT};
  endproperty
  a_sub: assert property (p_sub) else $error("submenu entered from wrong menu");
  property p_mode;
    $past(disp.menu) == kmrc_pkg::M_RUN && disp.menu != kmrc_pkg::M_RUN
      |-> disp.menu == kmrc_pkg::M_MODE;
  endproperty
  a_mode: assert property (p_mode) else $error("run menu left to wrong menu");
  property p_item;
    disp.menu == kmrc_pkg::M_SUB |-> disp.item <= kmrc_pkg::items_last(disp.entry);
  endproperty
  a_item: assert property (p_item) else $error("submenu item beyond list");
  property p_bl;
    $rose(backlight_on) |-> idle_q < 4'h8;
  endproperty
  a_bl: assert property (p_bl) else $error("backlight lit without key");
  property p_cfg;
    cfg_q <= CFG_IDLE_MS * MS_CYCLES + 2 * MS_CYCLES + 4;
  endproperty
  a_cfg: assert property (p_cfg) else $error("config idle return late");
  c_edit: cover property (disp.menu == kmrc_pkg::M_EDIT);
  c_nv: cover property (nv.conv_we);
  c_wok: cover property ($rose(disp.write_ok));
endmodule

// ---- tb/kmrc_operator_model.sv ----
module kmrc_operator_model (
  // clock and keys
  input  wire logic       sys_clk,
  output logic      [5:0] key_raw
);
  timeunit 1ns;
  timeprecision 1ps;
  initial key_raw = 6'h0;
  // released keys fall to the pull-down level; gap outlasts debounce
  task automatic press(input int k, input int hold);
    key_raw[k] <= 1'b1;
    repeat (hold) @(posedge sys_clk);
    key_raw[k] <= 1'b0;
    repeat (40) @(posedge sys_clk);
  endtask
endmodule

// ---- tb/kmrc_menu_ctrl_tb_top.sv ----
module kmrc_menu_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    sys_clk = 1'b0;
  logic                    srst = 1'b1;
  logic [5:0]              key_raw;
  logic                    fault_raw = 1'b0, reverse_raw = 1'b0, sound_out_raw = 1'b0;
  logic                    selftest_done_raw = 1'b1;
  logic [7:0]              reg_addr = 8'h0;
  logic [31:0]             reg_wdata = 32'h0, reg_rdata, e;
  logic                    reg_wr = 1'b0, reg_rd = 1'b0, rd_q = 1'b0, r1, r2;
  logic                    backlight_on, relay1_on, relay2_on;
  kmrc_pkg::kmrc_disp_type disp;
  kmrc_pkg::kmrc_nv_type   nv;
  int                      miscompares = 0, n_checks = 0;
  integer                  seed = 32'hb1faf945;
  logic [31:0]             exp_q[$], msk_q[$];
  always #12.5 sys_clk = ~sys_clk;
  kmrc_operator_model kmrc_operator_model_inst (.sys_clk(sys_clk), .key_raw(key_raw));
  // backlight span outlasts a 100-cycle home hold plus the settle gap, so lit checks hold
  kmrc_menu_ctrl #(.MS_CYCLES(4), .DEBOUNCE_CYCLES(4), .HOME_HOLD_MS(10), .BACKLIGHT_MS(60),
    .CFG_IDLE_MS(400)) kmrc_menu_ctrl_inst (.sys_clk(sys_clk),
    .srst(srst), .key_raw(key_raw), .fault_raw(fault_raw), .reverse_raw(reverse_raw),
    .sound_out_raw(sound_out_raw), .selftest_done_raw(selftest_done_raw), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .disp(disp), .backlight_on(backlight_on), .fault_flash(), .relay1_on(relay1_on),
    .relay2_on(relay2_on), .nv(nv));
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [31:0] x, input logic [31:0] m);
    exp_q.push_back(x);
    msk_q.push_back(m);
    reg_addr <= kmrc_pkg::REG_STATUS;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  // status word: menu, write access, backlight, entry, item
  task automatic chk(input kmrc_pkg::kmrc_menu_type m, input logic w, input logic [2:0] en,
    input logic [1:0] i, input logic b);
    rd({19'h0, i, en, 3'h0, b, w, m}, (m >= kmrc_pkg::M_MAIN) ? 32'h1f1f : 32'h1f);
  endtask
  task automatic p(input int k, input int n);
    repeat (n) kmrc_operator_model_inst.press(k, 20);
  endtask
  // result watcher pairs each read with its oldest note
  always @(posedge sys_clk) begin
    if (rd_q) begin
      e = exp_q.pop_front() ^ (reg_rdata & msk_q.pop_front());
      n_checks++;
      if (e !== 32'h0) begin
        miscompares++;
        $display("MISMATCH status diff %h seen %h", e, reg_rdata);
      end
    end
    rd_q <= reg_rd;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    chk(kmrc_pkg::M_RUN, 0, 0, 0, 1);
    p(1, 1);
    kmrc_operator_model_inst.press(0, 100);
    chk(kmrc_pkg::M_MODE, 0, 0, 0, 1);
    p(0, 1);
    chk(kmrc_pkg::M_RUN, 0, 0, 0, 1);
    kmrc_operator_model_inst.press(0, 100);
    p(1, 1);
    p(5, 1);
    p(3, 1);
    p(5, 1);
    chk(kmrc_pkg::M_MAIN, 0, 0, 0, 1);
    p(5, 2);
    chk(kmrc_pkg::M_SUB, 0, 0, 0, 1);
    p(0, 1);
    kmrc_operator_model_inst.press(0, 100);
    p(1, 1);
    p(5, 1);
    p(4, 3);
    p(3, 1);
    p(5, 1);
    chk(kmrc_pkg::M_MAIN, 1, 0, 0, 1);
    p(1, 6);
    chk(kmrc_pkg::M_MAIN, 1, 0, 0, 1);
    p(2, 1);
    chk(kmrc_pkg::M_MAIN, 1, 5, 0, 1);
    p(1, 1);
    p(5, 1);
    p(1, 2);
    chk(kmrc_pkg::M_SUB, 1, 0, 2, 1);
    p(1, 1);
    chk(kmrc_pkg::M_SUB, 1, 0, 0, 1);
    p(5, 1);
    chk(kmrc_pkg::M_EDIT, 1, 0, 0, 1);
    p(3, 1);
    p(5, 1);
    chk(kmrc_pkg::M_SUB, 1, 0, 0, 1);
    kmrc_operator_model_inst.press(0, 100);
    repeat (1700) @(posedge sys_clk);
    chk(kmrc_pkg::M_RUN, 0, 0, 0, 0);
    p(1, 1);
    chk(kmrc_pkg::M_RUN, 0, 0, 0, 1);
    for (int i = 0; i < 9; i++) begin
      {fault_raw, reverse_raw, sound_out_raw} <= 3'($random(seed));
      reg_addr <= kmrc_pkg::REG_CTRL;
      reg_wdata <= {28'h0, 2'(i / 3), 2'(i % 3)};
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      repeat (8) @(posedge sys_clk);
      r1 = (i % 3 == 0) ? !fault_raw : (i % 3 == 1) ? reverse_raw : sound_out_raw;
      r2 = (i / 3 == 2) ? sound_out_raw : reverse_raw;
      rd({24'h0, r2, r1, 6'h0}, 32'hc0);
    end
    repeat (2) @(posedge sys_clk);
    close_out();
  end
endmodule
bind kmrc_menu_ctrl kmrc_menu_ctrl_checker #(.MS_CYCLES(MS_CYCLES), .CFG_IDLE_MS(CFG_IDLE_MS))
  kmrc_menu_ctrl_checker_inst (.sys_clk(sys_clk), .srst(srst), .key_raw(key_raw),
  .disp(disp), .backlight_on(backlight_on), .nv(nv));
